// ===== src/pcpc_pkg.sv
// Purpose: Shared constants for the pixel clock phase and coast control.
// Assumes: Registers sit one per aligned 32-bit word at four times their index.
// Notes: Polarity fields hold 2'b01 for an active-high input.
package pcpc_pkg;
  localparam int PHASE_W = 5;
  localparam int PHASE_STEPS = 32;
  localparam int DIV_W = 12;
  localparam int CNT_W = 16;
  localparam int REF_CLK_MHZ = 125;
  localparam logic [7:0] IDX_DIV_HI = 8'h01;
  localparam logic [7:0] IDX_DIV_LO = 8'h02;
  localparam logic [7:0] IDX_PHASE = 8'h04;
  localparam logic [7:0] IDX_HS_POL = 8'h12;
  localparam logic [7:0] IDX_COAST_POL = 8'h18;
  localparam logic [7:0] IDX_GEAR = 8'h36;
  localparam logic [7:0] IDX_CTRL = 8'h3A;
  localparam logic [7:0] IDX_STATUS = 8'h3B;
  localparam int PHASE_LSB = 3;
  localparam int HS_POL_LSB = 4;
  localparam int COAST_POL_LSB = 5;
  localparam int DIV_LO_LSB = 4;
  localparam int CTRL_EXT_CLK = 0;
  localparam int CTRL_INT_COAST = 1;
  localparam int CTRL_VS_HIGH = 2;
  localparam int STAT_LOCK = 0;
  localparam int STAT_COAST = 1;
  localparam int STAT_CNT_LSB = 16;
  localparam logic [1:0] POL_HIGH = 2'h1;
  localparam logic [1:0] POL_RESET = 2'h1;
  localparam logic [11:0] DIV_RESET = 12'h0400;
  localparam logic [4:0] PHASE_RESET = 5'h00;
  localparam logic [2:0] CTRL_RESET = 3'h6;
endpackage : pcpc_pkg

// ===== src/pcpc_phase_if.sv
// Purpose: Carries pixel timing between the loop and the phase shifter.
// Assumes: One clock domain, ref_clk.
// Notes: The shifter owns the applied phase and the aligned sync.
`timescale 1ns/10ps
interface pcpc_phase_if;
  logic        ext_sel;
  logic        pix_tick;
  logic [4:0]  nco_frac;
  logic [15:0] ext_cnt;
  logic [15:0] ext_period;
  logic [4:0]  phase_req;
  logic        hsync_act;
  logic        sample_tick;
  logic [4:0]  phase_now;
  logic        hs_aligned;
  modport ctrl (output ext_sel, pix_tick, nco_frac, ext_cnt, ext_period, phase_req,
                hsync_act, input sample_tick, phase_now, hs_aligned);
  modport shift (input ext_sel, pix_tick, nco_frac, ext_cnt, ext_period, phase_req,
                 hsync_act, output sample_tick, phase_now, hs_aligned);
endinterface : pcpc_phase_if

// ===== src/pcpc_phase_shift.sv
// Purpose: Places the sampling strobe at one of 32 steps of the pixel period.
// Assumes: The oscillator advances less than one step per ref_clk cycle.
// Notes: A new phase is taken only at a pixel boundary, so no strobe is lost or doubled.
`timescale 1ns/10ps
module pcpc_phase_shift
  import pcpc_pkg::*;
(
  input wire logic   ref_clk, // System clock.
  input wire logic   rst_n,   // Synchronous reset, active low.
  pcpc_phase_if.shift pif     // Pixel timing from the loop.
);
  logic [4:0]  phase_now;
  logic [4:0]  next_phase_now;
  logic [4:0]  prev_frac;
  logic        prev_at;
  logic        next_prev_at;
  logic        hs_aligned;
  logic        next_hs_aligned;
  logic [20:0] thr;
  logic        at_ext;
  logic        hit;

  // External clock: the strobe falls where count*32 first reaches period*phase.
  assign thr    = pif.ext_period * phase_now;
  assign at_ext = {pif.ext_cnt, 5'h00} >= thr;

  always_comb begin
    if (pif.ext_sel) begin
      hit = at_ext && !prev_at;
    end else begin
      hit = (pif.nco_frac != prev_frac) && (pif.nco_frac == phase_now);
    end
    next_prev_at    = pif.pix_tick ? 1'b0 : at_ext;
    next_phase_now  = pif.pix_tick ? pif.phase_req : phase_now;
    next_hs_aligned = hit ? pif.hsync_act : hs_aligned;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phase_now  <= PHASE_RESET;
      prev_frac  <= 5'h00;
      prev_at    <= 1'b0;
      hs_aligned <= 1'b0;
    end else begin
      phase_now  <= next_phase_now;
      prev_frac  <= pif.nco_frac;
      prev_at    <= next_prev_at;
      hs_aligned <= next_hs_aligned;
    end
  end

  assign pif.sample_tick = hit;
  assign pif.phase_now   = phase_now;
  assign pif.hs_aligned  = hs_aligned;

  sequence frac_step;
    !pif.ext_sel && (pif.nco_frac != $past(pif.nco_frac));
  endsequence

  phase_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frac_step and (pif.nco_frac == phase_now) |-> pif.sample_tick)
    else $error("strobe missing at the programmed phase step");
  hs_align_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(hs_aligned) |-> $past(pif.sample_tick) && (hs_aligned == $past(pif.hsync_act)))
    else $error("aligned sync moved away from the sampling strobe");
  ext_phase_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pif.ext_sel && pif.sample_tick |-> ({pif.ext_cnt, 5'h00} >= thr))
    else $error("external clock strobe ahead of its phase");
  phase_apply_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(phase_now) |-> $past(pif.pix_tick) && (phase_now == $past(pif.phase_req)))
    else $error("phase changed away from a pixel boundary");
endmodule : pcpc_phase_shift

// ===== src/pcpc_top.sv
// Purpose: Line-locked pixel clock loop with phase shift, coast and polarity control.
// Assumes: All pins are synchronous to ref_clk; the pixel clock is an enable pulse.
// Notes: Pixel rate must stay below 125/32 MHz so every phase step is visited.
// What this block does
// - Phase field gives 32 sampling steps
// - Sync output carries the same phase shift
// - Phase shift also works with external clock
// - Coast freezes frequency, ignores hsync
// - Coast polarity at register 0x18 bits 6:5
// - Hsync polarity at register 0x12 bits 5:4
// - Polarity value 1 means active high
// - Internal coast follows vertical sync
// - Divided clock compared with hsync, corrects oscillator
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
module pcpc_top
  import pcpc_pkg::*;
#(
  parameter logic [31:0] FW_INIT    = 32'h0100_0000, // Starting frequency word.
  parameter int          GAIN_SHIFT = 4               // Loop gain as a left shift.
) (
  input  wire logic        ref_clk,                 // 125 MHz system clock.
  input  wire logic        rst_n,                   // Synchronous reset, active low.
  input  wire logic        psel,                    // APB select.
  input  wire logic        penable,                 // APB access phase.
  input  wire logic        pwrite,                  // APB write.
  input  wire logic [11:0] paddr,                   // APB byte address.
  input  wire logic [31:0] pwdata,                  // APB write data.
  output logic      [31:0] prdata,                  // APB read data.
  output logic             pready,                  // APB ready.
  output logic             pslverr,                 // APB error on unmapped word.
  input  wire logic        hsync_in,                // Horizontal sync pin.
  input  wire logic        vsync_in,                // Vertical sync pin.
  input  wire logic        coast_in,                // External coast pin.
  input  wire logic        ext_pix_tick,            // External pixel clock enable.
  output logic             pix_tick_out,            // Internal pixel clock enable.
  output logic             sample_clk_en,           // Phase-shifted sampling strobe.
  output logic             phase_aligned_hsync_out, // Sync with the sampling phase.
  output logic             pll_locked               // Last line count within one.
);
  import pcpc_pkg::*;

  pcpc_phase_if pif ();

  logic [11:0] div;
  logic [11:0] next_div;
  logic [4:0]  phase;
  logic [4:0]  next_phase;
  logic [1:0]  hs_pol;
  logic [1:0]  next_hs_pol;
  logic [1:0]  coast_pol;
  logic [1:0]  next_coast_pol;
  logic        oscillator_low_rate_select;
  logic        next_low_rate;
  logic [2:0]  ctrl;
  logic [2:0]  next_ctrl;
  logic [31:0] prdata_q;
  logic [31:0] next_prdata;
  logic [31:0] rd_val;
  logic        map_hit;
  logic [7:0]  idx;
  logic        wr;

  logic        hsync_act;
  logic        coast_act;
  logic        vsync_act;
  logic        coasting;
  logic        hs_prev;
  logic        hs_edge;
  logic        take;
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic        pix_int;
  logic [31:0] fw;
  logic [31:0] next_fw;
  logic [11:0] pix_cnt;
  logic [11:0] next_pix_cnt;
  logic [11:0] line_cnt;
  logic [11:0] next_line_cnt;
  logic        skip;
  logic        next_skip;
  logic        locked;
  logic        next_locked;
  logic [12:0] err;
  logic [31:0] delta;
  logic [15:0] ext_cnt;
  logic [15:0] next_ext_cnt;
  logic [15:0] ext_period;
  logic [15:0] next_ext_period;
  logic        pix_q;
  logic        samp_q;

  // Register bus: zero wait states, read data captured in the setup cycle.
  assign idx    = paddr[9:2];
  assign wr     = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    map_hit = 1'b1;
    rd_val  = 32'h0000_0000;
    if (idx == IDX_DIV_HI) begin
      rd_val[7:0] = div[11:4];
    end else if (idx == IDX_DIV_LO) begin
      rd_val[DIV_LO_LSB +: 4] = div[3:0];
    end else if (idx == IDX_PHASE) begin
      rd_val[PHASE_LSB +: PHASE_W] = phase;
    end else if (idx == IDX_HS_POL) begin
      rd_val[HS_POL_LSB +: 2] = hs_pol;
    end else if (idx == IDX_COAST_POL) begin
      rd_val[COAST_POL_LSB +: 2] = coast_pol;
    end else if (idx == IDX_GEAR) begin
      rd_val[0] = oscillator_low_rate_select;
    end else if (idx == IDX_CTRL) begin
      rd_val[2:0] = ctrl;
    end else if (idx == IDX_STATUS) begin
      rd_val[STAT_LOCK]              = locked;
      rd_val[STAT_COAST]             = coasting;
      rd_val[STAT_CNT_LSB +: DIV_W]  = line_cnt;
    end else begin
      map_hit = 1'b0;
    end
  end

  assign pslverr = psel && penable && !map_hit;

  always_comb begin
    next_div       = div;
    next_phase     = phase;
    next_hs_pol    = hs_pol;
    next_coast_pol = coast_pol;
    next_low_rate  = oscillator_low_rate_select;
    next_ctrl      = ctrl;
    next_prdata    = (psel && !penable) ? rd_val : prdata_q;
    if (wr) begin
      if (idx == IDX_DIV_HI) begin
        next_div[11:4] = pwdata[7:0];
      end else if (idx == IDX_DIV_LO) begin
        next_div[3:0] = pwdata[DIV_LO_LSB +: 4];
      end else if (idx == IDX_PHASE) begin
        next_phase = pwdata[PHASE_LSB +: PHASE_W];
      end else if (idx == IDX_HS_POL) begin
        next_hs_pol = pwdata[HS_POL_LSB +: 2];
      end else if (idx == IDX_COAST_POL) begin
        next_coast_pol = pwdata[COAST_POL_LSB +: 2];
      end else if (idx == IDX_GEAR) begin
        next_low_rate = pwdata[0];
      end else if (idx == IDX_CTRL) begin
        next_ctrl = pwdata[2:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div                        <= DIV_RESET;
      phase                      <= PHASE_RESET;
      hs_pol                     <= POL_RESET;
      coast_pol                  <= POL_RESET;
      oscillator_low_rate_select <= 1'b0;
      ctrl                       <= CTRL_RESET;
      prdata_q                   <= 32'h0000_0000;
    end else begin
      div                        <= next_div;
      phase                      <= next_phase;
      hs_pol                     <= next_hs_pol;
      coast_pol                  <= next_coast_pol;
      oscillator_low_rate_select <= next_low_rate;
      ctrl                       <= next_ctrl;
      prdata_q                   <= next_prdata;
    end
  end

  assign prdata = prdata_q;

  // Input polarity and coast sources.
  assign hsync_act = (hs_pol == POL_HIGH) ? hsync_in : !hsync_in;
  assign coast_act = (coast_pol == POL_HIGH) ? coast_in : !coast_in;
  assign vsync_act = ctrl[CTRL_VS_HIGH] ? vsync_in : !vsync_in;
  assign coasting  = coast_act || (ctrl[CTRL_INT_COAST] && vsync_act);
  assign hs_edge   = hsync_act && !hs_prev;
  // The first edge after coast only restarts the count, since the count spans the gap.
  assign take      = hs_edge && !coasting && !skip;
  assign err       = {1'b0, pix_cnt} - {1'b0, div};
  assign delta     = {{19{err[12]}}, err} << (GAIN_SHIFT + int'(oscillator_low_rate_select));

  always_comb begin
    {pix_int, next_acc} = {1'b0, acc} + {1'b0, fw};
    next_fw       = fw;
    next_pix_cnt  = pix_int ? pix_cnt + 12'h001 : pix_cnt;
    next_line_cnt = line_cnt;
    next_locked   = locked;
    next_skip     = coasting ? 1'b1 : skip;
    if (hs_edge && !coasting) begin
      next_pix_cnt = 12'h000;
      next_skip    = 1'b0;
    end
    if (take) begin
      next_fw       = fw - delta;
      next_line_cnt = pix_cnt;
      next_locked   = (err == 13'h0000) || (err == 13'h0001) || (err == 13'h1FFF);
    end
    next_ext_cnt    = ext_pix_tick ? 16'h0000 : ext_cnt + 16'h0001;
    next_ext_period = ext_pix_tick ? ext_cnt + 16'h0001 : ext_period;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc        <= 32'h0000_0000;
      fw         <= FW_INIT;
      pix_cnt    <= 12'h000;
      line_cnt   <= 12'h000;
      skip       <= 1'b1;
      locked     <= 1'b0;
      hs_prev    <= 1'b0;
      ext_cnt    <= 16'h0000;
      ext_period <= 16'h0000;
      pix_q      <= 1'b0;
      samp_q     <= 1'b0;
    end else begin
      acc        <= next_acc;
      fw         <= next_fw;
      pix_cnt    <= next_pix_cnt;
      line_cnt   <= next_line_cnt;
      skip       <= next_skip;
      locked     <= next_locked;
      hs_prev    <= hsync_act;
      ext_cnt    <= next_ext_cnt;
      ext_period <= next_ext_period;
      pix_q      <= pix_int;
      samp_q     <= pif.sample_tick;
    end
  end

  // Phase shifter; it never touches the loop state, so a phase write keeps lock.
  assign pif.ext_sel    = ctrl[CTRL_EXT_CLK];
  assign pif.pix_tick   = ctrl[CTRL_EXT_CLK] ? ext_pix_tick : pix_int;
  assign pif.nco_frac   = acc[31:27];
  assign pif.ext_cnt    = ext_cnt;
  assign pif.ext_period = ext_period;
  assign pif.phase_req  = phase;
  assign pif.hsync_act  = hsync_act;

  pcpc_phase_shift u_shift (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pif     (pif)
  );

  assign pix_tick_out            = pix_q;
  assign sample_clk_en           = samp_q;
  assign phase_aligned_hsync_out = pif.hs_aligned;
  assign pll_locked              = locked;

  sequence line_taken;
    take && (err != 13'h0000);
  endsequence

  coast_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    coasting |=> $stable(fw))
    else $error("frequency word moved during coast");
  hs_pol_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    hsync_act == ((hs_pol == POL_HIGH) ~^ hsync_in))
    else $error("hsync polarity not applied");
  coast_pol_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (coast_pol == POL_HIGH) && coast_in |-> coasting)
    else $error("active-high coast did not hold the loop");
  int_coast_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl[CTRL_INT_COAST] && vsync_act |-> coasting ##1 skip)
    else $error("vertical sync did not start internal coast");
  lock_adj_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    line_taken |=> (fw == $past(fw) - $past(delta)) && (pix_cnt <= 12'h001))
    else $error("loop did not correct after a line");
  ext_clk_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ctrl[CTRL_EXT_CLK] && ext_pix_tick |=> (ext_cnt == 16'h0000))
    else $error("external pixel clock not tracked");
  phase_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr && (idx == IDX_PHASE) && !take && !coasting |=> $stable(fw) && $stable(locked))
    else $error("phase write disturbed the loop");
  read_back_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    psel && !penable && !pwrite && (idx == IDX_PHASE) |=> prdata[7:3] == $past(phase))
    else $error("phase field read back wrong");
endmodule : pcpc_top

// ===== bench/pcpc_sync_src.sv
// Purpose: Video source model that drives sync, coast and an external pixel clock.
// Assumes: One clock domain; all outputs change just after the rising edge.
// Notes: A disabled hsync sits at its idle level, as a lost cable would leave it.
`timescale 1ns/10ps
module pcpc_sync_src (
  input  wire logic        ref_clk,      // System clock.
  input  wire logic        rst_n,        // Synchronous reset, active low.
  input  wire logic        hs_en,        // Hsync pulses present.
  input  wire logic        hs_hi,        // Source drives active-high hsync.
  input  wire logic [15:0] line_len,     // Line length in cycles.
  input  wire logic [7:0]  ext_len,      // External pixel period in cycles.
  input  wire logic        vs_lvl,       // Vertical sync pin level.
  input  wire logic        coast_lvl,    // Coast pin level.
  output logic             hsync_in,     // Horizontal sync pin.
  output logic             vsync_in,     // Vertical sync pin.
  output logic             coast_in,     // Coast pin.
  output logic             ext_pix_tick  // External pixel pulse.
);
  logic [15:0] lc;
  logic [15:0] next_lc;
  logic [7:0]  pc;
  logic [7:0]  next_pc;
  always_comb begin
    next_lc = (lc + 16'h0001 >= line_len) ? 16'h0000 : lc + 16'h0001;
    next_pc = (pc + 8'h01 >= ext_len) ? 8'h00 : pc + 8'h01;
  end
  always_ff @(posedge ref_clk) begin
    lc <= rst_n ? next_lc : 16'h0000;
    pc <= rst_n ? next_pc : 8'h00;
  end
  // The pulse is a quarter line wide so it spans several pixels.
  assign hsync_in = (hs_en && lc < (line_len >> 2)) ? hs_hi : !hs_hi;
  assign vsync_in = vs_lvl;
  assign coast_in = coast_lvl;
  assign ext_pix_tick = rst_n && pc == 8'h00;
endmodule : pcpc_sync_src

// ===== bench/pixel_clock_phase_coast_control_tb.sv
// Purpose: Self-checking bench for the pixel clock phase and coast control.
// Assumes: Zero-wait APB slave; registers at four times their index.
// Notes: Loop settling time is not fixed, so lock is awaited under a bound.
`timescale 1ns/10ps
module pixel_clock_phase_coast_control_tb;
  import pcpc_pkg::*;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic        hsync_in, vsync_in, coast_in, ext_pix_tick, pix_tick_out, sample_clk_en;
  logic        phase_aligned_hsync_out, pll_locked, hs_en, hs_hi, vs_lvl, coast_lvl;
  logic        err_v, hs_prev;
  logic [15:0] line_len;
  logic [7:0]  ext_len;
  logic [3:0]  k;
  logic [11:0] cnt0;
  logic [31:0] model [int];
  logic [7:0]  ids [7] = '{IDX_DIV_HI, IDX_DIV_LO, IDX_PHASE, IDX_HS_POL, IDX_COAST_POL,
                           IDX_GEAR, IDX_CTRL};
  int          errors, comparisons, since_strobe, p, off, off0, n, t;
  // A stronger loop gain than the default lets the loop settle within a few lines.
  pcpc_top #(.GAIN_SHIFT(22)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hsync_in(hsync_in), .vsync_in(vsync_in), .coast_in(coast_in),
    .ext_pix_tick(ext_pix_tick), .pix_tick_out(pix_tick_out), .sample_clk_en(sample_clk_en),
    .phase_aligned_hsync_out(phase_aligned_hsync_out), .pll_locked(pll_locked));
  pcpc_sync_src u_src (.ref_clk(ref_clk), .rst_n(rst_n), .hs_en(hs_en), .hs_hi(hs_hi),
    .line_len(line_len), .ext_len(ext_len), .vs_lvl(vs_lvl), .coast_lvl(coast_lvl),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .coast_in(coast_in),
    .ext_pix_tick(ext_pix_tick));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic end_sim;
    $display("counts: comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int w;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge ref_clk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w >= 50) begin
      chk(w, 0);
      end_sim();
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps the next call from raising psel in this same time step.
    @(posedge ref_clk);
    if (wr) model[idx] = wd;
  endtask : apb
  task automatic rdchk(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd_v, model[idx]);
  endtask : rdchk
  // Which: 0 external tick, 1 lock, 2 hsync low, 3 hsync high.
  task automatic wait_sig(input int which, input int lim);
    int w;
    w = 0;
    do begin
      @(posedge ref_clk);
      w++;
    end while (!(which == 0 ? ext_pix_tick === 1'b1 : which == 1 ? pll_locked === 1'b1 :
                 hsync_in === (which == 3)) && w < lim);
    if (w >= lim) begin
      chk(w, lim + 1);
      end_sim();
    end
  endtask : wait_sig
  task automatic meas(output int o);
    wait_sig(0, 200);
    o = 0;
    do begin
      @(posedge ref_clk);
      o++;
    end while (sample_clk_en !== 1'b1 && o < 200);
  endtask : meas
  // The aligned sync may only move right after a sampling strobe.
  always @(posedge ref_clk) begin
    since_strobe = (sample_clk_en === 1'b1) ? 0 : since_strobe + 1;
    if (rst_n === 1'b1 && phase_aligned_hsync_out !== hs_prev) begin
      comparisons++;
      if (since_strobe > 0) begin
        errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, phase_aligned_hsync_out, hs_prev);
      end
    end
    hs_prev = phase_aligned_hsync_out;
  end
  initial begin
    {rst_n, psel, penable, pwrite, vs_lvl, coast_lvl, err_v, hs_prev} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {hs_en, hs_hi} = 2'b11;
    line_len = 16'h0140;
    ext_len = 8'h40;
    since_strobe = 99;
    foreach (ids[i]) model[ids[i]] = 32'h0000_0000;
    model[IDX_DIV_HI] = 32'h0000_0040;
    model[IDX_HS_POL] = 32'h0000_0010;
    model[IDX_COAST_POL] = 32'h0000_0020;
    model[IDX_CTRL] = 32'h0000_0006;
    void'($urandom(17));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (ids[i]) rdchk(ids[i]);
    apb(1'b0, 8'h05, 32'h0000_0000);
    chk({31'h0, err_v}, 32'h0000_0001);
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      apb(1'b1, IDX_CTRL, {29'h0, k[1], k[0], 1'b0});
      apb(1'b1, IDX_COAST_POL, k[3] ? 32'h0000_0020 : 32'h0000_0000);
      vs_lvl <= k[2];
      coast_lvl <= k[3] ^ k[1];
      repeat (4) @(posedge ref_clk);
      apb(1'b0, IDX_STATUS, 32'h0000_0000);
      chk(rd_v[STAT_COAST], ((k[3] ^ k[1]) == k[3]) || (k[0] && k[2] == k[1]));
    end
    vs_lvl <= 1'b0;
    coast_lvl <= 1'b0;
    apb(1'b1, IDX_COAST_POL, 32'h0000_0020);
    $display("test coast sources done");
    apb(1'b1, IDX_DIV_HI, 32'h0000_0000);
    apb(1'b1, IDX_DIV_LO, 32'h0000_0080);
    apb(1'b1, IDX_CTRL, 32'h0000_0004);
    wait_sig(1, 60000);
    repeat (700) @(posedge ref_clk);
    apb(1'b0, IDX_STATUS, 32'h0000_0000);
    chk(rd_v[27:16] >= 12'd7 && rd_v[27:16] <= 12'd9, 1);
    // One line of 320 cycles holds between 7 and 9 pixel pulses when locked to 8.
    n = 0;
    repeat (320) @(posedge ref_clk) n += (pix_tick_out === 1'b1);
    chk(n >= 7 && n <= 9, 1);
    p = $urandom_range(31, 1);
    apb(1'b1, IDX_PHASE, p << PHASE_LSB);
    rdchk(IDX_PHASE);
    n = 0;
    repeat (2000) @(posedge ref_clk) n += (pll_locked !== 1'b1);
    chk(n, 0);
    $display("test lock and phase change done");
    apb(1'b0, IDX_STATUS, 32'h0000_0000);
    cnt0 = rd_v[27:16];
    coast_lvl <= 1'b1;
    hs_en <= 1'b0;
    repeat (1500) @(posedge ref_clk);
    apb(1'b0, IDX_STATUS, 32'h0000_0000);
    chk(rd_v[27:16], cnt0);
    chk(rd_v[STAT_COAST], 1);
    hs_en <= 1'b1;
    coast_lvl <= 1'b0;
    $display("test coast hold done");
    apb(1'b1, IDX_CTRL, 32'h0000_0005);
    apb(1'b1, IDX_HS_POL, 32'h0000_0000);
    apb(1'b1, IDX_PHASE, 32'h0000_0000);
    hs_hi <= 1'b0;
    line_len <= 16'h0200;
    repeat (4) wait_sig(0, 200);
    meas(off0);
    // Phases stay below half a pixel so each strobe lands before the next tick.
    for (int j = 0; j < 4; j++) begin
      p = $urandom_range(15, 1);
      apb(1'b1, IDX_PHASE, p << PHASE_LSB);
      repeat (3) wait_sig(0, 200);
      meas(off);
      chk(off, off0 + 2 * p);
      apb(1'b1, IDX_PHASE, $urandom_range(15, 1) << PHASE_LSB);
      wait_sig(0, 200);
      n = 0;
      t = 0;
      while (t < 8 && n < 50) begin
        @(posedge ref_clk);
        t += (ext_pix_tick === 1'b1);
        n += (sample_clk_en === 1'b1);
      end
      chk(n, 8);
    end
    wait_sig(3, 1000);
    wait_sig(2, 1000);
    repeat (80) @(posedge ref_clk);
    chk(phase_aligned_hsync_out, 1);
    repeat (200) @(posedge ref_clk);
    chk(phase_aligned_hsync_out, 0);
    $display("test external clock phase done");
    end_sim();
  end
endmodule : pixel_clock_phase_coast_control_tb
